/* File: verilog/arcf_pkg.sv */
// constants for the converter configuration and fault register bank
//
// Function
// R01: with oversampling off, resolution boost is ignored; default width used
// R02: boost bit 2: 0 normal width, 1 adds two result bits while oversampling
// R03: reference select bit 1: 0 internal source, 1 external source
// R04: power-down bit 0 at 1 puts the converter in shutdown
// R05: register word carries register address in bits 15 to 12 both ways
// R06: lane select bit 8: 0 both data pins, 1 first pin only
// R07: reset code 0x3c gives soft reset, registers keep their values
// R08: soft reset clears fault register, flushes oversampling, idles state machines; code clears only write-check flag bit 9, load-error flag bit 8 kept
// R09: reset code 0xff gives hard reset, registers return to defaults
// R10: any other reset field value takes no reset action
// R11: rejected write with bad check code sets write-check flag bit 9
// R12: write-check flag stays set until fault register read clears it
// R13: configuration load failure at startup sets load-error flag bit 8
// R14: load-error flag survives reads; hard reset clears it and reruns load
// R15: ratio codes 001 to 101 give x2 to x32; 000, 110, 111 disable
// R16: alert-pin enable honoured only while single-lane output selected
// R17: reserved bits read zero; writes to reserved or read-only bits ignored
`default_nettype none
package arcf_pkg;
    localparam logic [3:0] ADDR_CFG1 = 4'h1;
    localparam logic [3:0] ADDR_CFG2 = 4'h2;
    localparam logic [3:0] ADDR_FAULT = 4'h3;
    localparam int ADDR_MSB = 15;
    localparam int ADDR_LSB = 12;
    // first configuration register fields
    localparam int OS_MODE_BIT = 9;
    localparam int RATIO_MSB = 8;
    localparam int RATIO_LSB = 6;
    localparam int ALERT_EN_BIT = 3;
    localparam int BOOST_BIT = 2;
    localparam int REFERENCE_BIT = 1;
    localparam int PDOWN_BIT = 0;
    localparam logic [11:0] CFG1_WMASK = 12'h3cf;
    localparam logic [11:0] CFG1_RESET = 12'h000;
    // second configuration register fields
    localparam int LANE_BIT = 8;
    localparam logic [11:0] CFG2_WMASK = 12'h100;
    localparam logic [11:0] CFG2_RESET = 12'h000;
    localparam logic [7:0] CODE_SOFT = 8'h3c;
    localparam logic [7:0] CODE_HARD = 8'hff;
    // fault register fields
    localparam int WCHK_BIT = 9;
    localparam int LOAD_BIT = 8;
    localparam logic [2:0] RATIO_MAX_CODE = 3'h5;
    localparam int LOAD_CYCLES = 8;
    typedef enum logic [1:0] {LD_IDLE, LD_RUN, LD_DONE} arcf_load_type;
endpackage : arcf_pkg
`default_nettype wire

/* File: verilog/arcf_load_seq.sv */
// startup configuration load sequencer
`timescale 1ns/100ps
`default_nettype none
module arcf_load_seq #(
    parameter int LOAD_CYCLES = arcf_pkg::LOAD_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic restart_i,
    input wire logic load_ok_i,
    output logic busy_o,
    output logic fail_o
);
    arcf_pkg::arcf_load_type state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic fail_reg, fail_next;

    // load runs after the reset input and after each restart, result sampled at the end
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        fail_next = fail_reg;
        if (restart_i) begin
            state_next = arcf_pkg::LD_RUN; // R14
            cnt_next = 8'h00;
            fail_next = 1'b0;
        end else begin
            unique case (state_reg)
                arcf_pkg::LD_IDLE: begin
                    state_next = arcf_pkg::LD_RUN;
                end
                arcf_pkg::LD_RUN: begin
                    cnt_next = cnt_reg + 8'h01;
                    if (cnt_reg == 8'(LOAD_CYCLES - 1)) begin
                        state_next = arcf_pkg::LD_DONE;
                        fail_next = !load_ok_i; // R13
                    end
                end
                arcf_pkg::LD_DONE: begin
                    state_next = arcf_pkg::LD_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= arcf_pkg::LD_IDLE;
            cnt_reg <= 8'h00;
            fail_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            fail_reg <= fail_next;
        end
    end

    assign busy_o = (state_reg != arcf_pkg::LD_DONE);
    assign fail_o = fail_reg;
endmodule : arcf_load_seq
`default_nettype wire

/* File: verilog/arcf_regs.sv */
// configuration and fault register bank of the dual converter
`timescale 1ns/100ps
`default_nettype none
module arcf_regs #(
    parameter int LOAD_CYCLES = arcf_pkg::LOAD_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] wdata_i,
    input wire logic [3:0] raddr_i,
    input wire logic crc_err_i,
    input wire logic load_ok_i,
    output logic [15:0] rdata_o,
    output logic [2:0] oversample_ratio_o,
    output logic os_active_o,
    output logic resolution_boost_o,
    output logic [4:0] result_width_o,
    output logic reference_select_o,
    output logic power_down_select_o,
    output logic output_lane_select_o,
    output logic second_data_out_pin_en_o,
    output logic alert_pin_en_o,
    output logic soft_reset_o,
    output logic hard_reset_o,
    output logic load_busy_o
);
    logic [11:0] cfg1_reg, cfg1_next;
    logic [11:0] cfg2_reg, cfg2_next;
    logic wchk_reg, wchk_next;
    logic soft_reg, soft_next;
    logic hard_reg, hard_next;
    logic [15:0] rdata_reg, rdata_next;
    logic load_fail;
    logic [3:0] waddr;
    logic [7:0] wcode;
    logic wr_ok;

    // true for ratio codes that really oversample
    function automatic logic os_on(input logic [2:0] code);
        os_on = (code != 3'h0) && (code <= arcf_pkg::RATIO_MAX_CODE); // R15
    endfunction : os_on

    assign waddr = wdata_i[arcf_pkg::ADDR_MSB:arcf_pkg::ADDR_LSB]; // R05
    assign wcode = wdata_i[7:0];
    assign wr_ok = wr_i && !crc_err_i; // R11

    // hard reset reruns the configuration load
    arcf_load_seq #(
        .LOAD_CYCLES(LOAD_CYCLES)
    ) i_arcf_load_seq (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .restart_i(hard_reg),
        .load_ok_i(load_ok_i),
        .busy_o(load_busy_o),
        .fail_o(load_fail)
    );

    // register writes, reset codes and sticky flag
    always_comb begin
        cfg1_next = cfg1_reg;
        cfg2_next = cfg2_reg;
        wchk_next = wchk_reg;
        soft_next = 1'b0;
        hard_next = 1'b0;
        if (rd_i && raddr_i == arcf_pkg::ADDR_FAULT) begin
            wchk_next = 1'b0; // R12
        end
        if (soft_reg) begin
            wchk_next = 1'b0; // R08
        end
        if (wr_ok && waddr == arcf_pkg::ADDR_CFG1) begin
            cfg1_next = wdata_i[11:0] & arcf_pkg::CFG1_WMASK; // R17
        end
        if (wr_ok && waddr == arcf_pkg::ADDR_CFG2) begin
            cfg2_next = wdata_i[11:0] & arcf_pkg::CFG2_WMASK; // R17
            soft_next = (wcode == arcf_pkg::CODE_SOFT); // R07 R10
            hard_next = (wcode == arcf_pkg::CODE_HARD); // R09 R10
        end
        // set wins over a same-cycle read or soft-reset clear
        if (wr_i && crc_err_i) begin
            wchk_next = 1'b1; // R11
        end
        if (hard_reg) begin
            cfg1_next = arcf_pkg::CFG1_RESET; // R09
            cfg2_next = arcf_pkg::CFG2_RESET;
            wchk_next = 1'b0;
        end
    end

    // read data, address echoed in top nibble
    always_comb begin
        rdata_next = rdata_reg;
        if (rd_i) begin
            unique case (raddr_i)
                arcf_pkg::ADDR_CFG1: rdata_next = {raddr_i, cfg1_reg};
                arcf_pkg::ADDR_CFG2: rdata_next = {raddr_i, cfg2_reg};
                arcf_pkg::ADDR_FAULT: begin
                    rdata_next = {raddr_i, 12'h000};
                    rdata_next[arcf_pkg::WCHK_BIT] = wchk_reg;
                    rdata_next[arcf_pkg::LOAD_BIT] = load_fail; // R14
                end
                default: rdata_next = {raddr_i, 12'h000}; // R05
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cfg1_reg <= arcf_pkg::CFG1_RESET;
            cfg2_reg <= arcf_pkg::CFG2_RESET;
            wchk_reg <= 1'b0;
            soft_reg <= 1'b0;
            hard_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            cfg1_reg <= cfg1_next;
            cfg2_reg <= cfg2_next;
            wchk_reg <= wchk_next;
            soft_reg <= soft_next;
            hard_reg <= hard_next;
            rdata_reg <= rdata_next;
        end
    end

    // decoded controls for the converter core
    assign oversample_ratio_o = cfg1_reg[arcf_pkg::RATIO_MSB:arcf_pkg::RATIO_LSB];
    assign os_active_o = os_on(oversample_ratio_o); // R15
    assign resolution_boost_o = cfg1_reg[arcf_pkg::BOOST_BIT] && os_active_o; // R01 R02
    assign result_width_o = resolution_boost_o ? 5'h12 : 5'h10; // R02
    assign reference_select_o = cfg1_reg[arcf_pkg::REFERENCE_BIT]; // R03
    assign power_down_select_o = cfg1_reg[arcf_pkg::PDOWN_BIT]; // R04
    assign output_lane_select_o = cfg2_reg[arcf_pkg::LANE_BIT]; // R06
    assign second_data_out_pin_en_o = !output_lane_select_o; // R06
    assign alert_pin_en_o = output_lane_select_o && cfg1_reg[arcf_pkg::ALERT_EN_BIT]; // R16
    assign soft_reset_o = soft_reg; // R08
    assign hard_reset_o = hard_reg;
    assign rdata_o = rdata_reg;

    property p_wchk_set;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_i && crc_err_i && !hard_reg) |=> wchk_reg;
    endproperty
    a_wchk_set: assert property (p_wchk_set) else $error("write-check flag not set"); // R11

    property p_wchk_sticky;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wchk_reg && !rd_i && !soft_reg && !hard_reg) |=> wchk_reg;
    endproperty
    a_wchk_sticky: assert property (p_wchk_sticky) else $error("flag lost without read"); // R12

    property p_bad_write_ignored;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_i && crc_err_i && !hard_reg) |=> $stable(cfg1_reg) && !soft_reg;
    endproperty
    a_bad_write_ignored: assert property (p_bad_write_ignored) else $error("write taken"); // R11

    property p_soft_code;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_ok && waddr == arcf_pkg::ADDR_CFG2 && wcode == arcf_pkg::CODE_SOFT) |=> soft_reg;
    endproperty
    a_soft_code: assert property (p_soft_code) else $error("soft reset missed"); // R07

    property p_hard_defaults;
        @(posedge clk_sys_i) disable iff (rst_i)
        hard_reg |=> (cfg1_reg == arcf_pkg::CFG1_RESET) && (cfg2_reg == arcf_pkg::CFG2_RESET);
    endproperty
    a_hard_defaults: assert property (p_hard_defaults) else $error("values kept"); // R09

    property p_other_code;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_i && wcode != arcf_pkg::CODE_SOFT && wcode != arcf_pkg::CODE_HARD)
            |=> !soft_reg && !hard_reg;
    endproperty
    a_other_code: assert property (p_other_code) else $error("reset from other code"); // R10

    property p_soft_clears;
        @(posedge clk_sys_i) disable iff (rst_i)
        (soft_reg && !wr_i) |=> !wchk_reg && $stable(cfg1_reg);
    endproperty
    a_soft_clears: assert property (p_soft_clears) else $error("soft reset wrong"); // R08

    property p_res_ignored;
        @(posedge clk_sys_i) disable iff (rst_i)
        !os_active_o |-> !resolution_boost_o && result_width_o == 5'h10;
    endproperty
    a_res_ignored: assert property (p_res_ignored) else $error("boost without ratio"); // R01

    property p_alert_gate;
        @(posedge clk_sys_i) disable iff (rst_i)
        !output_lane_select_o |-> !alert_pin_en_o && second_data_out_pin_en_o;
    endproperty
    a_alert_gate: assert property (p_alert_gate) else $error("alert in two-lane mode"); // R16

    property p_addr_echo;
        @(posedge clk_sys_i) disable iff (rst_i)
        rd_i |=> rdata_o[15:12] == $past(raddr_i);
    endproperty
    a_addr_echo: assert property (p_addr_echo) else $error("address not echoed"); // R05

    // a rejected frame must not touch the second register or fire a hard reset
    property p_bad_cfg2;
        @(posedge clk_sys_i) disable iff (rst_i)
        (wr_i && crc_err_i && !hard_reg) |=> $stable(cfg2_reg) && !hard_reg;
    endproperty
    a_bad_cfg2: assert property (p_bad_cfg2) else $error("bad write used"); // R11

    // fault read with no new error in the same cycle drops the flag
    property p_rd_clear;
        @(posedge clk_sys_i) disable iff (rst_i)
        (rd_i && raddr_i == arcf_pkg::ADDR_FAULT && !(wr_i && crc_err_i)) |=> !wchk_reg;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read kept flag"); // R12

    // reads never clear the load flag, only the hard reset does
    property p_load_kept;
        @(posedge clk_sys_i) disable iff (rst_i)
        (load_fail && !hard_reg) |=> load_fail;
    endproperty
    a_load_kept: assert property (p_load_kept) else $error("load flag lost"); // R14

    property p_hard_reload;
        @(posedge clk_sys_i) disable iff (rst_i)
        hard_reg |=> load_busy_o && !load_fail;
    endproperty
    a_hard_reload: assert property (p_hard_reload) else $error("load not rerun"); // R14
endmodule : arcf_regs
`default_nettype wire

/* File: dv/arcf_host.sv */
// host controller model that issues register words and read strobes
`timescale 1ns/100ps
`default_nettype none
module arcf_host (
    input wire logic clk_sys_i,
    input wire logic [15:0] rdata_i,
    output logic wr_o,
    output logic rd_o,
    output logic [15:0] wdata_o,
    output logic [3:0] raddr_o,
    output logic crc_err_o
);
    // idle bus at time zero
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 16'h0000;
        raddr_o = 4'h0;
        crc_err_o = 1'b0;
    end
    // one whole word per strobe, held for one edge
    task automatic write(input logic [15:0] w, input logic bad);
        @(posedge clk_sys_i);
        wr_o <= 1'b1;
        wdata_o <= w;
        crc_err_o <= bad;
        @(posedge clk_sys_i);
        wr_o <= 1'b0;
        crc_err_o <= 1'b0;
        wdata_o <= ~w; // released lines show junk, so stale data cannot pass
    endtask : write
    // read word is settled just after the taking edge and sampled 1 ns later
    task automatic read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys_i);
        rd_o <= 1'b1;
        raddr_o <= a;
        @(posedge clk_sys_i);
        rd_o <= 1'b0;
        raddr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : read
endmodule : arcf_host
`default_nettype wire

/* File: dv/test_adc_config_fault_registers.sv */
// self-checking bench for the configuration and fault register bank
`timescale 1ns/100ps
`default_nettype none
module test_adc_config_fault_registers;
    logic clk_sys_i, rst_i, wr_i, rd_i, crc_err_i, load_ok_i;
    logic [15:0] wdata_i, rdata_o, rd_word;
    logic [3:0] raddr_i;
    logic [2:0] ratio_o;
    logic [4:0] width_o;
    logic os_o, boost_o, ref_o, pd_o, lane_o, sec_o, alert_o, soft_o, hard_o, busy_o;
    int n_fail = 0, n_compared = 0, seed = 83, n_soft = 0, n_hard = 0;
    int m_cfg1 = 0, m_cfg2 = 0, m_wchk = 0, m_load = 0, m_soft = 0, m_hard = 0;
    arcf_regs #(.LOAD_CYCLES(4)) i_arcf_regs (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .raddr_i(raddr_i),
        .crc_err_i(crc_err_i), .load_ok_i(load_ok_i), .rdata_o(rdata_o),
        .oversample_ratio_o(ratio_o), .os_active_o(os_o), .resolution_boost_o(boost_o),
        .result_width_o(width_o), .reference_select_o(ref_o),
        .power_down_select_o(pd_o), .output_lane_select_o(lane_o),
        .second_data_out_pin_en_o(sec_o), .alert_pin_en_o(alert_o),
        .soft_reset_o(soft_o), .hard_reset_o(hard_o), .load_busy_o(busy_o));
    arcf_host i_arcf_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .wr_o(wr_i),
        .rd_o(rd_i), .wdata_o(wdata_i), .raddr_o(raddr_i), .crc_err_o(crc_err_i));
    // 125 MHz system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    // pulse tallies; a stretched pulse shows up as an extra count
    always @(posedge clk_sys_i) begin
        if (soft_o === 1'b1) n_soft++;
        if (hard_o === 1'b1) n_hard++;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // model write; a rejected word changes only the flag
    task automatic wr(input logic [15:0] w, input logic bad);
        i_arcf_host.write(w, bad);
        if (bad) m_wchk = 1;
        else if (w[15:12] == 4'h1) m_cfg1 = w & 16'h03cf;
        else if (w[15:12] == 4'h2) begin
            m_cfg2 = w & 16'h0100;
            if (w[7:0] == 8'h3c) begin
                m_wchk = 0;
                m_soft++;
            end
            if (w[7:0] == 8'hff) begin
                m_cfg1 = 0;
                m_cfg2 = 0;
                m_wchk = 0;
                m_hard++;
            end
        end
    endtask : wr
    // model read; a fault read clears only the write-check flag
    task automatic rd(input logic [3:0] a);
        logic [15:0] e;
        e = {a, 12'h000};
        if (a == 4'h1) e[11:0] = m_cfg1[11:0];
        if (a == 4'h2) e[11:0] = m_cfg2[11:0];
        if (a == 4'h3) e[9:8] = {m_wchk[0], m_load[0]};
        i_arcf_host.read(a, rd_word);
        chk(rd_word, e, "read word");
        if (a == 4'h3) m_wchk = 0;
    endtask : rd
    // decoded control outputs against the model registers
    task automatic chk_outs;
        logic [15:0] c;
        logic os, ln;
        c = m_cfg1[15:0];
        ln = m_cfg2[8];
        os = c[8:6] inside {[3'h1:3'h5]};
        #1;
        chk({1'b0, lane_o, sec_o, alert_o, ratio_o, os_o, boost_o, ref_o, pd_o, width_o},
            {1'b0, ln, ~ln, c[3] & ln, c[8:6], os, c[2] & os, c[1], c[0],
            (c[2] & os) ? 5'h12 : 5'h10}, "control outputs");
        chk({15'h0, lane_o}, {15'h0, ln}, "lane select");
    endtask : chk_outs
    task automatic wait_load;
        int k;
        repeat (3) @(posedge clk_sys_i);
        for (k = 0; k < 100 && busy_o !== 1'b0; k++) @(posedge clk_sys_i);
        chk({15'h0, busy_o}, 16'h0000, "load finished");
        m_load = (load_ok_i === 1'b0);
    endtask : wait_load
    task automatic do_reset;
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        m_cfg1 = 0;
        m_cfg2 = 0;
        m_wchk = 0;
        wait_load;
    endtask : do_reset
    task automatic stop_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #160000;
        n_fail++;
        stop_test;
    end
    // main sequence
    initial begin
        logic [15:0] w;
        int i;
        rst_i = 1'b1;
        load_ok_i = 1'b1;
        do_reset;
        for (i = 1; i < 8; i++) rd(i[3:0]);
        chk_outs;
        $display("test reset_values done");
        for (i = 0; i < 24; i++) begin
            w = $random(seed);
            wr({4'h1, w[11:0]}, 1'b0);
            chk_outs;
            w = $random(seed);
            if (w[7:0] == 8'h3c || w[7:0] == 8'hff) w[7:0] = 8'h5a;
            wr({4'h2, w[11:0]}, 1'b0);
            chk_outs;
            rd(4'h1);
            rd(4'h2);
        end
        $display("test random_config done");
        wr(16'h3fff, 1'b0);
        wr(16'h7fff, 1'b0);
        wr(16'h21ff, 1'b1);
        wr(16'h1000, 1'b1);
        rd(4'h1);
        rd(4'h2);
        rd(4'h3);
        rd(4'h3);
        $display("test rejected_write done");
        wr(16'h1fff, 1'b1);
        wr(16'h213c, 1'b0);
        rd(4'h1);
        rd(4'h3);
        chk_outs;
        $display("test soft_reset done");
        @(posedge clk_sys_i);
        load_ok_i <= 1'b0;
        do_reset;
        rd(4'h3);
        rd(4'h3);
        @(posedge clk_sys_i);
        load_ok_i <= 1'b1;
        wr(16'h21ff, 1'b0);
        wait_load;
        rd(4'h1);
        rd(4'h2);
        rd(4'h3);
        chk_outs;
        chk(16'(n_soft), 16'(m_soft), "soft pulses");
        chk(16'(n_hard), 16'(m_hard), "hard pulses");
        $display("test hard_reset done");
        stop_test;
    end
endmodule : test_adc_config_fault_registers
`default_nettype wire
